// ---- rtl/i2c_slave_control_status.sv ----
// Two-wire slave control and status registers with bus-side sequencing
// ==========================================
// Summary of operation
// RULE1 - Address bits 7..1 hold seven-bit own address
// RULE2 - Address bit 0 is plain read/write storage
// RULE3 - Matching master address selects this slave
// RULE4 - Mode field picks peripheral, two-wire, or off
// RULE5 - Debounce clock input by 0, 2, 4 clocks
// RULE6 - Mode register bit 4 reads zero
// RULE7 - Enable low frees pins, idles the block
// RULE8 - Enable rise resets flags, keeps transmit/ack bits
// RULE9 - Enable rise leaves peripheral control untouched
// RULE10 - Early deselect sets incomplete and transfer flags
// RULE11 - Software incomplete write never sets transfer flag
// RULE12 - Byte-done low while moving, high after byte
// RULE13 - Match flag shows address compare result
// RULE14 - Busy set on START, cleared on STOP
// RULE15 - Transmit select chooses data direction
// RULE16 - Ack-send bit driven on ninth clock
// RULE17 - Software clears ack-send bit before next byte
// RULE18 - Read/write bit captured from address byte
// RULE19 - Wake on match when wake enable set
// RULE20 - Received ack flag sampled on ninth clock
// RULE21 - Transmitter stops and releases on no-ack
// RULE22 - START is data fall with clock high
// RULE23 - Address msb first, then read/write, then ack
// RULE24 - STOP is data rise with clock high
`timescale 1ns/100ps
`include "i2c_slave_params.svh"

module i2c_slave_control_status
  import i2c_slave_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire regReq_t regReq,
  output logic [7:0] rdData,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic spiSckPin,
  input wire logic spiSelN,
  output logic busEvent,
  output logic wakeReq
);

  // ==========================================
  // Registers
  logic [7:0] ownAddr_q;
  modeCtrl_t mode_q;
  statCtrl_t stat_q;
  spiCtrl_t spi_q;
  logic [7:0] txData_q;
  logic [7:0] rxData_q;
  logic enPrev_q;
  logic wrOwn, wrMode, wrStat, wrData, wrSpi;
  logic i2cOn, spiOn, enRise;

  assign wrOwn = regReq.wrStb && (regReq.addr == `REG_OWN_ADDR);
  assign wrMode = regReq.wrStb && (regReq.addr == `REG_MODE_CTRL);
  assign wrStat = regReq.wrStb && (regReq.addr == `REG_STAT_CTRL);
  assign wrData = regReq.wrStb && (regReq.addr == `REG_DATA);
  assign wrSpi = regReq.wrStb && (regReq.addr == `REG_SPI_CTRL);
  assign i2cOn = mode_q.moduleEnable && (mode_q.moduleModeSelect == `MODE_I2C_SLAVE); // RULE4 RULE7
  assign spiOn = mode_q.moduleEnable && (mode_q.moduleModeSelect == `MODE_SPI_SLAVE); // RULE4
  assign enRise = mode_q.moduleEnable && !enPrev_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ownAddr_q <= `OWN_ADDR_RST;
    end else if (wrOwn) begin
      ownAddr_q <= regReq.wrData; // RULE1 RULE2
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      enPrev_q <= 1'b0;
    end else begin
      enPrev_q <= mode_q.moduleEnable;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txData_q <= `DATA_RST;
    end else if (wrData) begin
      txData_q <= regReq.wrData;
    end
  end

  // ==========================================
  // Pin synchronisers and clock debounce
  logic sclS1_q, sclS2_q, sdaS1_q, sdaS2_q, sdaPrev_q;
  logic sclF_q, sclPrev_q;
  logic [2:0] debCnt_q;
  logic [2:0] debNeed;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclS1_q <= 1'b1;
      sclS2_q <= 1'b1;
      sdaS1_q <= 1'b1;
      sdaS2_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclS1_q <= sclPin;
      sclS2_q <= sclS1_q;
      sdaS1_q <= sdaPin;
      sdaS2_q <= sdaS1_q;
      sdaPrev_q <= sdaS2_q;
    end
  end

  always_comb begin
    if (mode_q.clockDebounceSelect[1]) begin
      debNeed = `DEB_FOUR; // RULE5
    end else if (mode_q.clockDebounceSelect[0]) begin
      debNeed = `DEB_TWO; // RULE5
    end else begin
      debNeed = `DEB_NONE; // RULE5
    end
  end

  // A new clock level is accepted only after it has held for the debounce length
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclF_q <= 1'b1;
      sclPrev_q <= 1'b1;
      debCnt_q <= `CNT_ZERO;
    end else begin
      sclPrev_q <= sclF_q;
      if (sclS2_q == sclF_q) begin
        debCnt_q <= `CNT_ZERO;
      end else if (debCnt_q >= debNeed) begin
        sclF_q <= sclS2_q; // RULE5
        debCnt_q <= `CNT_ZERO;
      end else begin
        debCnt_q <= debCnt_q + `CNT_ONE;
      end
    end
  end

  logic sclRise, sclFall, startDet, stopDet;
  assign sclRise = sclF_q && !sclPrev_q;
  assign sclFall = !sclF_q && sclPrev_q;
  assign startDet = sclF_q && sclPrev_q && sdaPrev_q && !sdaS2_q; // RULE22
  assign stopDet = sclF_q && sclPrev_q && !sdaPrev_q && sdaS2_q; // RULE24

  // ==========================================
  // Two-wire slave sequencer
  i2cState_t state_q;
  logic [2:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] txShift_q;
  logic ackPhase_q;
  logic lastRise, addrHit, addrEnd, rxEnd, txEnd, ackSample, byteBegin;

  assign lastRise = sclRise && (bitCnt_q == `LAST_BIT);
  assign addrHit = (shift_q[6:0] == ownAddr_q[7:1]); // RULE3 RULE23
  assign addrEnd = i2cOn && (state_q == ST_ADDR) && lastRise;
  assign rxEnd = i2cOn && (state_q == ST_RX) && lastRise;
  assign txEnd = i2cOn && (state_q == ST_TX) && lastRise;
  assign ackSample = i2cOn && (state_q == ST_TX_ACK) && sclRise && ackPhase_q;
  assign byteBegin = i2cOn && sclRise && (bitCnt_q == `CNT_ZERO) &&
                     ((state_q == ST_RX) || (state_q == ST_TX) || (state_q == ST_ADDR));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      bitCnt_q <= `CNT_ZERO;
      shift_q <= `DATA_RST;
      txShift_q <= `DATA_RST;
      ackPhase_q <= 1'b0;
      sdaOe <= 1'b0;
    end else if (!i2cOn) begin
      state_q <= ST_IDLE; // RULE7
      sdaOe <= 1'b0;
      ackPhase_q <= 1'b0;
    end else if (startDet) begin
      state_q <= ST_ADDR;
      bitCnt_q <= `CNT_ZERO;
      ackPhase_q <= 1'b0;
      sdaOe <= 1'b0;
    end else if (stopDet) begin
      state_q <= ST_IDLE;
      sdaOe <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_RX: begin
          if (sclRise) begin
            shift_q <= {shift_q[6:0], sdaS2_q}; // RULE23
            bitCnt_q <= bitCnt_q + `CNT_ONE;
          end
          if (lastRise) begin
            ackPhase_q <= 1'b0;
            if (state_q == ST_RX || addrHit) begin
              state_q <= ST_ACK_OUT;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ACK_OUT: begin
          if (sclFall && !ackPhase_q) begin
            ackPhase_q <= 1'b1;
            if (stat_q.addressMatchFlag) begin
              sdaOe <= 1'b1; // RULE23
            end else begin
              sdaOe <= !stat_q.ackSendBit; // RULE16
            end
          end else if (sclFall) begin
            ackPhase_q <= 1'b0;
            bitCnt_q <= `CNT_ZERO;
            if (stat_q.transmitSelect) begin
              state_q <= ST_TX; // RULE15
              sdaOe <= !txData_q[7];
              txShift_q <= {txData_q[6:0], 1'b0};
            end else begin
              state_q <= ST_RX; // RULE15
              sdaOe <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            sdaOe <= !txShift_q[7];
            txShift_q <= {txShift_q[6:0], 1'b0};
          end
          if (sclRise) begin
            bitCnt_q <= bitCnt_q + `CNT_ONE;
          end
          if (lastRise) begin
            state_q <= ST_TX_ACK;
            ackPhase_q <= 1'b0;
          end
        end
        ST_TX_ACK: begin
          if (sclFall && !ackPhase_q) begin
            ackPhase_q <= 1'b1;
            sdaOe <= 1'b0;
          end else if (sclFall) begin
            ackPhase_q <= 1'b0;
            bitCnt_q <= `CNT_ZERO;
            if (!stat_q.ackReceivedFlag) begin
              state_q <= ST_TX; // RULE21
              sdaOe <= !txData_q[7];
              txShift_q <= {txData_q[6:0], 1'b0};
            end else begin
              state_q <= ST_IDLE; // RULE21
              sdaOe <= 1'b0;
            end
          end
        end
        default: begin
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: the data pin is only ever pulled low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxData_q <= `DATA_RST;
    end else if (rxEnd) begin
      rxData_q <= {shift_q[6:0], sdaS2_q};
    end
  end

  // ==========================================
  // Status and control flags; hardware sets win over software writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stat_q <= `STAT_CTRL_RST;
    end else begin
      if (wrStat) begin
        stat_q.transmitSelect <= regReq.wrData[4];
        stat_q.ackSendBit <= regReq.wrData[3]; // RULE17
        stat_q.readWriteCapture <= regReq.wrData[2];
        stat_q.matchWakeupEnable <= regReq.wrData[1]; // RULE19
      end
      if (enRise && i2cOn) begin
        stat_q.byteDoneFlag <= 1'b1; // RULE8
        stat_q.addressMatchFlag <= 1'b0;
        stat_q.busBusyFlag <= 1'b0;
        stat_q.readWriteCapture <= 1'b0;
        stat_q.ackReceivedFlag <= 1'b1;
      end else if (i2cOn) begin
        if (startDet) begin
          stat_q.busBusyFlag <= 1'b1; // RULE14
          stat_q.addressMatchFlag <= 1'b0;
        end else if (stopDet) begin
          stat_q.busBusyFlag <= 1'b0; // RULE14
        end
        if (byteBegin) begin
          stat_q.byteDoneFlag <= 1'b0; // RULE12
          if (state_q != ST_ADDR) begin
            stat_q.addressMatchFlag <= 1'b0;
          end
        end
        if (addrEnd) begin
          stat_q.addressMatchFlag <= addrHit; // RULE13
          if (addrHit) begin
            stat_q.readWriteCapture <= sdaS2_q; // RULE18
            stat_q.byteDoneFlag <= 1'b1;
          end
        end
        if (rxEnd || txEnd) begin
          stat_q.byteDoneFlag <= 1'b1; // RULE12
        end
        if (ackSample) begin
          stat_q.ackReceivedFlag <= sdaS2_q; // RULE20
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busEvent <= 1'b0;
      wakeReq <= 1'b0;
    end else begin
      busEvent <= (addrEnd && addrHit) || rxEnd || txEnd; // RULE12
      wakeReq <= addrEnd && addrHit && stat_q.matchWakeupEnable; // RULE19
    end
  end

  // ==========================================
  // Peripheral-slave incomplete detection
  logic sckS1_q, sckS2_q, sckPrev_q, selS1_q, selS2_q, selPrev_q;
  logic [2:0] spiCnt_q;
  logic spiArmed, spiSckRise, spiDesel, spiEarly, spiByte;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sckS1_q <= 1'b0;
      sckS2_q <= 1'b0;
      sckPrev_q <= 1'b0;
      selS1_q <= 1'b1;
      selS2_q <= 1'b1;
      selPrev_q <= 1'b1;
    end else begin
      sckS1_q <= spiSckPin;
      sckS2_q <= sckS1_q;
      sckPrev_q <= sckS2_q;
      selS1_q <= spiSelN;
      selS2_q <= selS1_q;
      selPrev_q <= selS2_q;
    end
  end

  assign spiArmed = spiOn && spi_q.chipSelectEnable;
  assign spiSckRise = sckS2_q && !sckPrev_q && !selS2_q;
  assign spiDesel = selS2_q && !selPrev_q;
  assign spiEarly = spiArmed && spiDesel && (spiCnt_q != `CNT_ZERO); // RULE10
  assign spiByte = spiArmed && spiSckRise && (spiCnt_q == `LAST_BIT);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spiCnt_q <= `CNT_ZERO;
    end else if (!spiArmed || spiDesel) begin
      spiCnt_q <= `CNT_ZERO;
    end else if (spiSckRise) begin
      spiCnt_q <= spiCnt_q + `CNT_ONE;
    end
  end

  // Control fields are left alone on an enable rise so software setup survives
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_q <= `MODE_CTRL_RST;
    end else begin
      if (wrMode) begin
        mode_q <= regReq.wrData; // RULE4 RULE11
        mode_q.unusedBit <= 1'b0; // RULE6
      end
      if (spiEarly) begin
        mode_q.slaveIncompleteFlag <= 1'b1; // RULE10
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spi_q <= `SPI_CTRL_RST;
    end else begin
      if (wrSpi) begin
        spi_q.chipSelectEnable <= regReq.wrData[0]; // RULE9
        spi_q.transferFlag <= regReq.wrData[1];
      end
      if (spiEarly || spiByte) begin
        spi_q.transferFlag <= 1'b1; // RULE10 RULE11
      end
    end
  end

  // ==========================================
  // Read port, data valid the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdData <= `DATA_RST;
    end else if (!regReq.rdStb) begin
      rdData <= `DATA_RST;
    end else if (regReq.addr == `REG_OWN_ADDR) begin
      rdData <= ownAddr_q;
    end else if (regReq.addr == `REG_MODE_CTRL) begin
      rdData <= mode_q; // RULE6
    end else if (regReq.addr == `REG_STAT_CTRL) begin
      rdData <= stat_q;
    end else if (regReq.addr == `REG_DATA) begin
      rdData <= rxData_q;
    end else if (regReq.addr == `REG_SPI_CTRL) begin
      rdData <= spi_q;
    end else begin
      rdData <= `DATA_RST;
    end
  end

endmodule : i2c_slave_control_status

// ---- inc/i2c_slave_params.svh ----
// Register offsets, field codes, reset values and debounce counts
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH
// ==========================================
// Register map
`define REG_OWN_ADDR 3'h0
`define REG_MODE_CTRL 3'h1
`define REG_STAT_CTRL 3'h2
`define REG_DATA 3'h3
`define REG_SPI_CTRL 3'h4
// ==========================================
// Reset values
`define MODE_CTRL_RST 8'he0
`define STAT_CTRL_RST 8'h81
`define OWN_ADDR_RST 8'h00
`define SPI_CTRL_RST 8'h00
`define DATA_RST 8'h00
// ==========================================
// Mode codes
`define MODE_SPI_SLAVE 3'h5
`define MODE_I2C_SLAVE 3'h6
// ==========================================
// Debounce lengths in system clocks
`define DEB_NONE 3'h0
`define DEB_TWO 3'h2
`define DEB_FOUR 3'h4
// ==========================================
// Bit counting
`define LAST_BIT 3'h7
`define CNT_ZERO 3'h0
`define CNT_ONE 3'h1
`endif

// ---- inc/i2c_slave_pkg.sv ----
// Types shared by the two-wire slave control and status block
package i2c_slave_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK_OUT = 6'h04,
    ST_RX = 6'h08,
    ST_TX = 6'h10,
    ST_TX_ACK = 6'h20
  } i2cState_t;
  typedef struct packed {
    logic [2:0] moduleModeSelect;
    logic unusedBit;
    logic [1:0] clockDebounceSelect;
    logic moduleEnable;
    logic slaveIncompleteFlag;
  } modeCtrl_t;
  typedef struct packed {
    logic byteDoneFlag;
    logic addressMatchFlag;
    logic busBusyFlag;
    logic transmitSelect;
    logic ackSendBit;
    logic readWriteCapture;
    logic matchWakeupEnable;
    logic ackReceivedFlag;
  } statCtrl_t;
  typedef struct packed {
    logic [5:0] spare;
    logic transferFlag;
    logic chipSelectEnable;
  } spiCtrl_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wrData;
    logic wrStb;
    logic rdStb;
  } regReq_t;
endpackage : i2c_slave_pkg

// ---- dv/i2c_slave_control_status_sva.sv ----
// Checker for the two-wire slave control and status block
`timescale 1ns/100ps
`include "i2c_slave_params.svh"
module i2c_slave_control_status_sva
  import i2c_slave_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire regReq_t regReq,
  input wire logic [7:0] rdData,
  input wire logic sclPin,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic busEvent,
  input wire logic wakeReq
);
  // ==========================================
  // Shadows of software-only controls
  logic [7:0] modeQ;
  logic wakeQ;
  logic i2cOn;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      modeQ <= `MODE_CTRL_RST;
    end else if (regReq.wrStb && regReq.addr == `REG_MODE_CTRL) begin
      modeQ <= regReq.wrData;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wakeQ <= 1'b0;
    end else if (regReq.wrStb && regReq.addr == `REG_STAT_CTRL) begin
      wakeQ <= regReq.wrData[1];
    end
  end
  assign i2cOn = modeQ[7:5] == `MODE_I2C_SLAVE && modeQ[1];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Write then read of the same register
  sequence ownWrRd;
    regReq.wrStb && regReq.addr == `REG_OWN_ADDR ##2 regReq.rdStb && regReq.addr == `REG_OWN_ADDR;
  endsequence
  sequence modeWrRd;
    regReq.wrStb && regReq.addr == `REG_MODE_CTRL ##2 regReq.rdStb && regReq.addr == `REG_MODE_CTRL;
  endsequence
  a_own_addr_back: assert property (ownWrRd |=> rdData == $past(regReq.wrData, 3))
    else $error("own address readback differs");
  a_mode_fields_back: assert property (modeWrRd |=> rdData[7:1] ==
      {$past(regReq.wrData[7:5], 3), 1'b0, $past(regReq.wrData[3:1], 3)})
    else $error("mode fields readback differs");
  a_mode_bit_zero: assert property (regReq.rdStb && regReq.addr == `REG_MODE_CTRL |=> !rdData[4])
    else $error("mode bit 4 not zero");
  a_read_idle_zero: assert property (!regReq.rdStb |=> rdData == 8'h00)
    else $error("read data outside read slot");
  a_off_no_drive: assert property (!i2cOn [*3] |-> !sdaOe)
    else $error("data line driven while link off");
  a_open_drain: assert property (sdaOe |-> !sdaOut)
    else $error("data line driven high");
  a_steady_clock_high: assert property (sclPin [*6] |-> $stable(sdaOe))
    else $error("data drive changed in clock high");
  a_event_one_pulse: assert property (busEvent |-> i2cOn ##1 !busEvent)
    else $error("bus event not a single pulse");
  a_wake_when_enabled: assert property (wakeReq |-> wakeQ ##1 !wakeReq)
    else $error("wake request without enable");
endmodule : i2c_slave_control_status_sva

bind i2c_slave_control_status i2c_slave_control_status_sva chk (
  .clk(clk), .reset_n(reset_n), .regReq(regReq), .rdData(rdData), .sclPin(sclPin),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .busEvent(busEvent), .wakeReq(wakeReq)
);

// ---- dv/i2c_master_model.sv ----
// Behavioural two-wire bus master driving the slave's link pins
`timescale 1ns/100ps
module i2c_master_model (
  input wire logic sdaLine,
  output logic scl,
  output logic sdaRel
);
  // ==========================================
  // Both lines pulled up; clock stands high outside frames
  initial begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end
  // ==========================================
  // One bit of a 320 ns clock; data moves only while clock is low
  task automatic clockBit(input logic d, output logic s);
    scl = 1'b0;
    #100;
    sdaRel = d;
    #60;
    scl = 1'b1;
    #140;
    s = sdaLine;
    #20;
  endtask : clockBit
  task automatic startCond();
    sdaRel = 1'b1;
    #160;
    sdaRel = 1'b0;
    #160;
  endtask : startCond
  task automatic stopCond();
    logic s;
    clockBit(1'b0, s);
    sdaRel = 1'b1;
    #160;
  endtask : stopCond
  task automatic writeByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clockBit(b[i], s);
    end
    clockBit(1'b1, ack);
  endtask : writeByte
  task automatic readByte(input logic ackBit, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clockBit(1'b1, s);
      b[i] = s;
    end
    clockBit(ackBit, s);
  endtask : readByte
endmodule : i2c_master_model

// ---- dv/i2c_slave_control_status_bench.sv ----
// Self-checking bench for the two-wire slave control and status block
`timescale 1ns/100ps
`include "i2c_slave_params.svh"
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("ERROR at %0t: got %h expected %h", $time, g, e); \
    end \
  end
module i2c_slave_control_status_bench
  import i2c_slave_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  regReq_t regReq = '0;
  logic spiSckPin = 1'b0;
  logic spiSelN = 1'b1;
  logic [7:0] rdData;
  logic sdaOut, sdaOe, busEvent, wakeReq, scl, sdaRel, ack;
  logic [7:0] b;
  wire logic sdaLine;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int wakes = 0;
  int events = 0;
  assign sdaLine = ~(sdaOe | ~sdaRel);
  always #20 clk = ~clk;
  i2c_slave_control_status dut (
    .clk(clk), .reset_n(reset_n), .regReq(regReq), .rdData(rdData), .sclPin(scl),
    .sdaPin(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .spiSckPin(spiSckPin),
    .spiSelN(spiSelN), .busEvent(busEvent), .wakeReq(wakeReq)
  );
  i2c_master_model master (.sdaLine(sdaLine), .scl(scl), .sdaRel(sdaRel));
  // ==========================================
  // Register bus cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq.addr <= a;
    regReq.wrData <= d;
    regReq.wrStb <= 1'b1;
    @(posedge clk);
    regReq.wrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    regReq.addr <= a;
    regReq.rdStb <= 1'b1;
    @(posedge clk);
    regReq.rdStb <= 1'b0;
    #1;
    `CHK(rdData, e)
  endtask : rd
  // ==========================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] m;
    rd(`REG_MODE_CTRL, 8'he0);
    rd(`REG_STAT_CTRL, 8'h81);
    rd(`REG_SPI_CTRL, 8'h00);
    wr(`REG_OWN_ADDR, 8'ha5);
    rd(`REG_OWN_ADDR, 8'ha5);
    for (int i = 0; i < 8; i++) begin
      m = {i[2:0], 1'b1, i[1:0], 2'b10};
      wr(`REG_MODE_CTRL, m);
      rd(`REG_MODE_CTRL, m & 8'hef);
    end
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00);
    wr(`REG_STAT_CTRL, 8'hff);
    rd(`REG_STAT_CTRL, 8'h9f);
    wr(`REG_MODE_CTRL, 8'hc0);
    wr(`REG_MODE_CTRL, 8'hc2);
    rd(`REG_STAT_CTRL, 8'h9b);
  endtask : t_regs
  task automatic t_spi();
    wr(`REG_MODE_CTRL, 8'ha0);
    wr(`REG_SPI_CTRL, 8'h01);
    wr(`REG_MODE_CTRL, 8'ha2);
    rd(`REG_SPI_CTRL, 8'h01);
    @(posedge clk) spiSelN <= 1'b0;
    repeat (3) begin
      repeat (4) @(posedge clk);
      spiSckPin <= 1'b1;
      repeat (4) @(posedge clk);
      spiSckPin <= 1'b0;
    end
    repeat (4) @(posedge clk);
    spiSelN <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`REG_MODE_CTRL, 8'ha3);
    rd(`REG_SPI_CTRL, 8'h03);
    wr(`REG_SPI_CTRL, 8'h01);
    wr(`REG_MODE_CTRL, 8'ha2);
    wr(`REG_MODE_CTRL, 8'ha3);
    rd(`REG_SPI_CTRL, 8'h01);
  endtask : t_spi
  task automatic t_rx();
    wr(`REG_MODE_CTRL, 8'hc2);
    wr(`REG_OWN_ADDR, 8'hb4);
    wr(`REG_STAT_CTRL, 8'h00);
    master.startCond();
    rd(`REG_STAT_CTRL, 8'ha1);
    master.writeByte(8'hb4, ack);
    `CHK(ack, 1'b0)
    rd(`REG_STAT_CTRL, 8'he1);
    master.writeByte(8'h3c, ack);
    `CHK(ack, 1'b0)
    rd(`REG_DATA, 8'h3c);
    rd(`REG_STAT_CTRL, 8'ha1);
    wr(`REG_STAT_CTRL, 8'h08);
    master.writeByte(8'h55, ack);
    `CHK(ack, 1'b1)
    master.stopCond();
    // The stop clock's rising edge already opens a new byte, so byte done reads low
    rd(`REG_STAT_CTRL, 8'h09);
    master.startCond();
    master.writeByte(8'h22, ack);
    `CHK(ack, 1'b1)
    master.stopCond();
    `CHK(events, 3)
  endtask : t_rx
  task automatic t_tx();
    wr(`REG_STAT_CTRL, 8'h12);
    wr(`REG_DATA, 8'h26);
    master.startCond();
    master.writeByte(8'hb5, ack);
    `CHK(ack, 1'b0)
    rd(`REG_STAT_CTRL, 8'hf7);
    `CHK(wakes, 1)
    wr(`REG_STAT_CTRL, 8'h14);
    master.readByte(1'b0, b);
    `CHK(b, 8'h26)
    rd(`REG_STAT_CTRL, 8'hb4);
    master.readByte(1'b1, b);
    `CHK(b, 8'h26)
    master.stopCond();
    `CHK(sdaOe, 1'b0)
    rd(`REG_STAT_CTRL, 8'h95);
    `CHK(events, 6)
    // Traffic with the module disabled must find no responder and leave the flags alone
    wr(`REG_MODE_CTRL, 8'hc0);
    master.startCond();
    master.writeByte(8'hb5, ack);
    `CHK(ack, 1'b1)
    master.stopCond();
    rd(`REG_STAT_CTRL, 8'h95);
  endtask : t_tx
  // ==========================================
  // Verdict, watchdog and main sequence
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    if (wakeReq === 1'b1) begin
      wakes <= wakes + 1;
    end
    if (busEvent === 1'b1) begin
      events <= events + 1;
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_spi();
    t_rx();
    t_tx();
    final_report();
  end
endmodule : i2c_slave_control_status_bench
